// ==== hdl/aps_alarm_monitor.sv ====
// Protection switching alarm monitor with AXI4-Lite register access.
// Assumes K bytes and card presence inputs are synchronous to I_REF_CLK.
//
// Behaviour
// - Transmitted K1 carries this end's switch request and channel.
// - Transmitted K2 carries bridge state and mode information.
// - Flag remote signal failure when received K2 mode shows AIS or RDI.
// - Bidirectional only: flag mismatch when received K2 channel differs.
// - Bidirectional: flag byte failure for bad, lower received K1 request.
// - Any mode: flag byte failure when received K bytes are unstable.
// - In 1+1, flag absent card when any pair card is missing.
// - Flag remote protection failure when far end reports protection fail.
// - Flag architecture mismatch; direction mismatch only under GR mode.
// - In 1+1, flag standard mismatch between local redundant cards.
// - Looping the line loops both lines and reports line loop alarm.
// - Standby alarms shown as current only with no higher alarm active.
// - Standby alarms are the standby line's integrated line alarms.
// - Seven protection alarms plus OK, deactivated and looped status.
// - Protection port LED follows the working port LED.
// - Backcard LED green while carrying traffic, yellow when unused.
// - 1+1 crossover: working backcard relays, both backcard LEDs green.
`timescale 1ns/1ps

module aps_alarm_monitor
    import prot_alarm_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic                          I_REF_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_CE,
    // AXI4-Lite write address and data.
    input  wire logic [prot_alarm_pkg::ADDR_W-1:0] I_AWADDR,
    input  wire logic                          I_AWVALID,
    output logic                               O_AWREADY,
    input  wire logic [prot_alarm_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic [3:0]                    I_WSTRB,
    input  wire logic                          I_WVALID,
    output logic                               O_WREADY,
    // AXI4-Lite write response.
    output logic [1:0]                         O_BRESP,
    output logic                               O_BVALID,
    input  wire logic                          I_BREADY,
    // AXI4-Lite read.
    input  wire logic [prot_alarm_pkg::ADDR_W-1:0] I_ARADDR,
    input  wire logic                          I_ARVALID,
    output logic                               O_ARREADY,
    output logic [prot_alarm_pkg::DATA_W-1:0]  O_RDATA,
    output logic [1:0]                         O_RRESP,
    output logic                               O_RVALID,
    input  wire logic                          I_RREADY,
    // Received K bytes from the far end.
    input  wire logic [7:0]                    I_RX_K1,
    input  wire logic [7:0]                    I_RX_K2,
    // Local line and card state.
    input  wire logic                          I_PROT_SF,
    input  wire logic [3:0]                    I_CARD_PRESENT,
    input  wire logic [prot_alarm_pkg::NSTBY-1:0] I_STBY_ALARMS,
    input  wire logic [1:0]                    I_WORK_LED,
    // Transmitted K bytes.
    output logic [7:0]                         O_TX_K1,
    output logic [7:0]                         O_TX_K2,
    // Line loop and LEDs.
    output logic                               O_LOOP_WORK,
    output logic                               O_LOOP_PROT,
    output logic                               O_XOVER,
    output prot_alarm_pkg::led_t               O_WORK_BC_LED,
    output prot_alarm_pkg::led_t               O_PROT_BC_LED,
    output prot_alarm_pkg::led_t               O_PROT_PORT_LED,
    // Alarm status and interrupt.
    output prot_alarm_pkg::alarm_code_t        O_ALARM_CODE,
    output logic [prot_alarm_pkg::NSTBY-1:0]   O_STBY_STATUS,
    output logic                               O_IRQ
);
    import prot_alarm_pkg::*;

    // =====================================================================
    // Registers
    logic [7:0]        ctrl_r;
    logic [7:0]        txk1_r;
    logic [7:0]        txk2_r;
    logic [NALM-1:0]   irq_st_r;
    logic [NALM-1:0]   irq_en_r;
    logic [NALM-1:0]   alarm_r;
    logic [7:0]        rxk1_q;
    logic [7:0]        rxk2_q;
    logic [7:0]        stab_r;
    logic [7:0]        rxk1_ok_r;
    logic [7:0]        rxk2_ok_r;
    logic              aw_got_r;
    logic              w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0]        wstrb_r;

    // =====================================================================
    // Field decode of control and K bytes
    wire en_w      = ctrl_r[CTRL_ENABLE];
    wire bidir_w   = ctrl_r[CTRL_BIDIR];
    wire onep1_w   = ctrl_r[CTRL_ONE_P1];
    wire gr_w      = ctrl_r[CTRL_GR];
    wire mate_gr_w = ctrl_r[CTRL_MATEGR];
    wire loop_w    = ctrl_r[CTRL_LOOP];
    wire protac_w  = ctrl_r[CTRL_PROTAC];
    wire wfront_w  = ctrl_r[CTRL_WFRONT];
    // K1: request in bits 7:4, channel in 3:0. K2: channel 7:4, arch bit 3,
    // mode 2:0 (101 bidirectional, 100 unidirectional, 110 AIS, 111 RDI).
    wire [3:0] rx_req_w  = rxk1_ok_r[7:4];
    wire [3:0] tx_req_w  = txk1_r[7:4];
    wire [3:0] tx_ch_w   = txk1_r[3:0];
    wire [3:0] rx_ch2_w  = rxk2_ok_r[7:4];
    wire       rx_arch_w = rxk2_ok_r[3];
    wire [2:0] rx_mode_w = rxk2_ok_r[2:0];
    wire       rx_bidir_w = (rx_mode_w == 3'h5);
    wire       rx_unid_w  = (rx_mode_w == 3'h4);
    wire       rx_rdi_w   = (rx_mode_w == 3'h7) || (rx_mode_w == 3'h6);
    wire       rev_req_w  = (rx_req_w == 4'h2);
    wire       rx_sfp_w   = (rx_req_w == 4'hF) || (rx_req_w == 4'hC
                            && rxk1_ok_r[3:0] == 4'h0);
    wire       stable_w   = (stab_r >= STABLE_CNT);

    // =====================================================================
    // Protection-specific alarm conditions
    logic [NALM-1:0] cond_w;
    assign cond_w[A_RSF]  = en_w && stable_w && rx_rdi_w;
    assign cond_w[A_CHM]  = en_w && bidir_w && stable_w
                            && (rx_ch2_w != tx_ch_w);
    assign cond_w[A_PSB]  = en_w && (!stable_w
                            || (bidir_w && !rev_req_w
                                && (rx_req_w < tx_req_w)));
    assign cond_w[A_CARD] = en_w && onep1_w && (I_CARD_PRESENT != 4'hF);
    assign cond_w[A_FEPF] = en_w && stable_w && rx_sfp_w;
    assign cond_w[A_ARCH] = en_w && stable_w && ((rx_arch_w != onep1_w)
                            || (gr_w && ((bidir_w && rx_unid_w)
                                || (!bidir_w && rx_bidir_w))));
    assign cond_w[A_STD]  = en_w && onep1_w && (gr_w != mate_gr_w);
    assign cond_w[A_LOOP] = en_w && loop_w;

    // Priority encoder picks the current alarm code; standby last.
    alarm_code_t code_nxt;
    always_comb begin
        code_nxt = CODE_OK;
        if (!en_w) begin
            code_nxt = CODE_OFF;
        end else if (cond_w[A_RSF]) begin
            code_nxt = CODE_RSF;
        end else if (cond_w[A_CHM]) begin
            code_nxt = CODE_CHM;
        end else if (cond_w[A_PSB]) begin
            code_nxt = CODE_PSB;
        end else if (cond_w[A_CARD]) begin
            code_nxt = CODE_CARD;
        end else if (cond_w[A_FEPF]) begin
            code_nxt = CODE_FEPF;
        end else if (cond_w[A_ARCH]) begin
            code_nxt = CODE_ARCH;
        end else if (cond_w[A_STD]) begin
            code_nxt = CODE_STD;
        end else if (cond_w[A_LOOP]) begin
            code_nxt = CODE_LOOP;
        end else if (|I_STBY_ALARMS) begin
            code_nxt = CODE_STBY;
        end
    end

    // Backcard usage: working backcard busy when working line active or
    // relaying crossover traffic; protection backcard busy when active.
    wire xover_w   = onep1_w && wfront_w && protac_w;
    wire work_use_w = !protac_w || xover_w;
    wire prot_use_w = protac_w;
    wire led_t work_led_w = work_use_w ? LED_GREEN : LED_YELLOW;
    wire led_t prot_led_w = prot_use_w ? LED_GREEN : LED_YELLOW;

    // =====================================================================
    // AXI4-Lite decode
    wire aw_hs_w  = I_AWVALID && O_AWREADY;
    wire w_hs_w   = I_WVALID && O_WREADY;
    wire aw_have_w = aw_got_r || aw_hs_w;
    wire w_have_w  = w_got_r || w_hs_w;
    wire [ADDR_W-1:0] wa_w = aw_got_r ? awaddr_r : I_AWADDR;
    wire [DATA_W-1:0] wd_w = w_got_r ? wdata_r : I_WDATA;
    wire [3:0]        ws_w = w_got_r ? wstrb_r : I_WSTRB;
    wire do_wr_w  = aw_have_w && w_have_w && !O_BVALID;
    wire wr_ctrl_w = do_wr_w && (wa_w == OFS_CTRL) && ws_w[0];
    wire wr_txk_w  = do_wr_w && (wa_w == OFS_TXK);
    wire wr_en_w   = do_wr_w && (wa_w == OFS_IRQ_EN) && ws_w[0];
    wire wr_clr_w  = do_wr_w && (wa_w == OFS_IRQ_CLR) && ws_w[0];
    wire wr_ok_w   = (wa_w == OFS_CTRL) || (wa_w == OFS_TXK)
                     || (wa_w == OFS_IRQ_EN) || (wa_w == OFS_IRQ_CLR);
    wire rd_hs_w   = I_ARVALID && O_ARREADY;
    logic [DATA_W-1:0] rd_data_w;
    logic              rd_ok_w;
    always_comb begin
        rd_ok_w   = 1'b1;
        rd_data_w = '0;
        unique case (I_ARADDR)
            OFS_CTRL:    rd_data_w = {24'h0000_00, ctrl_r};
            OFS_TXK:     rd_data_w = {16'h0000, txk2_r, txk1_r};
            OFS_RXK:     rd_data_w = {16'h0000, rxk2_ok_r, rxk1_ok_r};
            OFS_ALARM:   rd_data_w = {16'h0000, 4'h0, O_ALARM_CODE,
                                      alarm_r};
            OFS_IRQ_ST:  rd_data_w = {24'h0000_00, irq_st_r};
            OFS_IRQ_EN:  rd_data_w = {24'h0000_00, irq_en_r};
            OFS_IRQ_CLR: rd_data_w = '0;
            OFS_LINE:    rd_data_w = {20'h0000_0, I_STBY_ALARMS};
            default:     rd_ok_w   = 1'b0;
        endcase
    end

    // =====================================================================
    // AXI write channel capture and response.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= RESP_OKAY;
        end else if (I_CE) begin
            if (aw_hs_w) begin
                awaddr_r <= I_AWADDR;
            end
            if (w_hs_w) begin
                wdata_r <= I_WDATA;
                wstrb_r <= I_WSTRB;
            end
            aw_got_r  <= aw_have_w && !do_wr_w;
            w_got_r   <= w_have_w && !do_wr_w;
            O_AWREADY <= !aw_have_w && !O_BVALID && !O_AWREADY;
            O_WREADY  <= !w_have_w && !O_BVALID && !O_WREADY;
            if (do_wr_w) begin
                O_BVALID <= 1'b1;
                O_BRESP  <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
            end else if (I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // AXI read channel.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= '0;
            O_RRESP   <= RESP_OKAY;
        end else if (I_CE) begin
            O_ARREADY <= !O_RVALID && !O_ARREADY && I_ARVALID;
            if (rd_hs_w) begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_data_w;
                O_RRESP  <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // Software-written control and transmit K bytes.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_r   <= CTRL_RST;
            txk1_r   <= '0;
            txk2_r   <= '0;
            irq_en_r <= '0;
        end else if (I_CE) begin
            if (wr_ctrl_w) begin
                ctrl_r <= wd_w[7:0];
            end
            if (wr_txk_w && ws_w[0]) begin
                txk1_r <= wd_w[7:0];
            end
            if (wr_txk_w && ws_w[1]) begin
                txk2_r <= wd_w[15:8];
            end
            if (wr_en_w) begin
                irq_en_r <= wd_w[NALM-1:0];
            end
        end
    end

    // Received K byte stability filter: a value counts once held steady.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rxk1_q    <= '0;
            rxk2_q    <= '0;
            stab_r    <= '0;
            rxk1_ok_r <= '0;
            rxk2_ok_r <= '0;
        end else if (I_CE) begin
            rxk1_q <= I_RX_K1;
            rxk2_q <= I_RX_K2;
            if (I_RX_K1 != rxk1_q || I_RX_K2 != rxk2_q) begin
                stab_r <= '0;
            end else if (!stable_w) begin
                stab_r <= stab_r + 8'h01;
            end else begin
                rxk1_ok_r <= rxk1_q;
                rxk2_ok_r <= rxk2_q;
            end
        end
    end

    // Sticky interrupt status; a new event wins over a clear.
    genvar g;
    generate
        for (g = 0; g < NALM; g++) begin : g_irq
            always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    irq_st_r[g] <= 1'b0;
                end else if (I_CE) begin
                    if (cond_w[g] && !alarm_r[g]) begin
                        irq_st_r[g] <= 1'b1;
                    end else if (wr_clr_w && wd_w[g]) begin
                        irq_st_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Registered outputs: alarms, code, loops, LEDs and interrupt.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            alarm_r         <= '0;
            O_ALARM_CODE    <= CODE_OK;
            O_STBY_STATUS   <= '0;
            O_TX_K1         <= '0;
            O_TX_K2         <= '0;
            O_LOOP_WORK     <= 1'b0;
            O_LOOP_PROT     <= 1'b0;
            O_XOVER         <= 1'b0;
            O_WORK_BC_LED   <= LED_OFF;
            O_PROT_BC_LED   <= LED_OFF;
            O_PROT_PORT_LED <= LED_OFF;
            O_IRQ           <= 1'b0;
        end else if (I_CE) begin
            alarm_r         <= cond_w;
            O_ALARM_CODE    <= code_nxt;
            O_STBY_STATUS   <= I_STBY_ALARMS;
            O_TX_K1         <= txk1_r;
            O_TX_K2         <= txk2_r;
            O_LOOP_WORK     <= loop_w;
            O_LOOP_PROT     <= loop_w;
            O_XOVER         <= xover_w;
            O_WORK_BC_LED   <= work_led_w;
            O_PROT_BC_LED   <= prot_led_w;
            O_PROT_PORT_LED <= led_t'(I_WORK_LED);
            O_IRQ           <= |(irq_st_r & irq_en_r);
        end
    end

endmodule

// ==== hdl/prot_alarm_pkg.sv ====
// Constants, register map and alarm encodings for the protection alarm block.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register master.
package prot_alarm_pkg;

    // =====================================================================
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // =====================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TXK     = 8'h04;
    localparam logic [7:0] OFS_RXK     = 8'h08;
    localparam logic [7:0] OFS_ALARM   = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFS_LINE    = 8'h1C;

    // =====================================================================
    // Control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_BIDIR  = 1;
    localparam int CTRL_ONE_P1 = 2;
    localparam int CTRL_GR     = 3;
    localparam int CTRL_MATEGR = 4;
    localparam int CTRL_LOOP   = 5;
    localparam int CTRL_PROTAC = 6;
    localparam int CTRL_WFRONT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // =====================================================================
    // Stability window for received K bytes, in clock cycles.
    localparam logic [7:0] STABLE_CNT = 8'h03;

    // =====================================================================
    // Protection alarm bits, highest priority first.
    localparam int NALM = 8;
    localparam int A_RSF  = 0;
    localparam int A_CHM  = 1;
    localparam int A_PSB  = 2;
    localparam int A_CARD = 3;
    localparam int A_FEPF = 4;
    localparam int A_ARCH = 5;
    localparam int A_STD  = 6;
    localparam int A_LOOP = 7;
    localparam int NSTBY = 12;

    // Current alarm code presented to software.
    typedef enum logic [3:0] {
        CODE_OK, CODE_OFF, CODE_RSF, CODE_CHM, CODE_PSB, CODE_CARD,
        CODE_FEPF, CODE_ARCH, CODE_STD, CODE_LOOP, CODE_STBY
    } alarm_code_t;

    // LED colours.
    typedef enum logic [1:0] {
        LED_OFF, LED_GREEN, LED_YELLOW, LED_RED
    } led_t;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== testbench/aps_alarm_monitor_assertions.sv ====
// Concurrent checks on the ports of the protection alarm monitor.
// Assumes one clock domain and a bench that keeps I_CE high.
`timescale 1ns/1ps

module aps_alarm_monitor_checker
    import prot_alarm_pkg::*;
(
    // Clock and reset.
    input logic                        I_REF_CLK,
    input logic                        I_RST_N,
    input logic                        I_CE,
    // Bus handshakes.
    input logic                        I_AWVALID,
    input logic                        O_AWREADY,
    input logic                        I_WVALID,
    input logic                        O_WREADY,
    input logic [1:0]                  O_BRESP,
    input logic                        O_BVALID,
    input logic                        I_BREADY,
    input logic                        I_ARVALID,
    input logic                        O_ARREADY,
    input logic [DATA_W-1:0]           O_RDATA,
    input logic                        O_RVALID,
    input logic                        I_RREADY,
    // Line state and indications.
    input logic [1:0]                  I_WORK_LED,
    input logic [NSTBY-1:0]            I_STBY_ALARMS,
    input prot_alarm_pkg::led_t        O_PROT_PORT_LED,
    input logic [NSTBY-1:0]            O_STBY_STATUS,
    input logic                        O_LOOP_WORK,
    input logic                        O_LOOP_PROT,
    input logic                        O_XOVER,
    input prot_alarm_pkg::led_t        O_WORK_BC_LED,
    input prot_alarm_pkg::led_t        O_PROT_BC_LED,
    input prot_alarm_pkg::alarm_code_t O_ALARM_CODE
);
    // =====================================================================
    // Checks
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);

    // Both halves of a write, and a read address, taken at one edge.
    sequence s_wr_taken;
        I_CE && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    sequence s_rd_taken;
        I_CE && I_ARVALID && O_ARREADY;
    endsequence

    a_wr_answer: assert property (s_wr_taken |-> ##[1:2] O_BVALID)
        else $error("no write answer");
    a_rd_answer: assert property (s_rd_taken |=> O_RVALID)
        else $error("no read data");
    a_b_stands: assert property (O_BVALID && !I_BREADY |=>
        O_BVALID && $stable(O_BRESP)) else $error("bresp dropped");
    a_r_stands: assert property (O_RVALID && !I_RREADY |=>
        O_RVALID && $stable(O_RDATA)) else $error("rdata dropped");
    a_port_led: assert property (I_CE |=>
        O_PROT_PORT_LED == $past(I_WORK_LED)) else $error("port led apart");
    a_stby_follow: assert property (I_CE |=>
        O_STBY_STATUS == $past(I_STBY_ALARMS)) else $error("standby lost");
    a_loop_pair: assert property (O_LOOP_WORK == O_LOOP_PROT)
        else $error("only one line looped");
    a_loop_code: assert property (O_ALARM_CODE == CODE_LOOP |->
        O_LOOP_WORK) else $error("loop code without loop");
    a_xover_green: assert property (O_XOVER |-> ##[0:1]
        O_WORK_BC_LED == LED_GREEN && O_PROT_BC_LED == LED_GREEN)
        else $error("crossover not green");
    a_stby_code: assert property (O_ALARM_CODE == CODE_STBY |->
        $past(I_STBY_ALARMS) != 0) else $error("standby code alone");
endmodule

// ==== testbench/aps_alarm_monitor_bench.sv ====
// Self-checking bench for the protection alarm monitor over AXI4-Lite.
// Assumes the package constants and the remote end model.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end

module aps_alarm_monitor_bench;
    import prot_alarm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psf = 1'b0, jit = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, rk1 = 8'h0, rk2 = 8'h4;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [11:0] stby = 12'h0, stby_st;
    logic [7:0] k1, k2, tx_k1, tx_k2;
    logic [3:0] card = 4'hF;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, lpw, lpp, xover, irq;
    led_t work_led = LED_OFF, wbc, pbc, ppl;
    alarm_code_t code;
    int mismatches = 0, comparisons = 0, cyc = 0;
    // Alarm cases: control, sent K1, received K1 and K2, expected code.
    logic [31:0] tc [14] = '{32'h0101_0004, 32'h0101_0006, 32'h0301_0025,
        32'h0101_F004, 32'h0101_000C, 32'h0501_000C, 32'h0D01_000C,
        32'h2101_0004, 32'h0001_0004, 32'h0301_0015, 32'h0351_3115,
        32'h1901_0005, 32'h0101_0005, 32'h0101_0004};
    alarm_code_t t_exp [14] = '{CODE_STBY, CODE_RSF, CODE_CHM, CODE_FEPF,
        CODE_ARCH, CODE_CARD, CODE_STD, CODE_LOOP, CODE_OFF, CODE_OK,
        CODE_PSB, CODE_ARCH, CODE_OK, CODE_PSB};

    // =====================================================================
    // Clock, design, far end and checker
    always #20 clk = ~clk;
    aps_alarm_monitor uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(1'b1),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(1'b1),
        .I_RX_K1(k1), .I_RX_K2(k2), .I_PROT_SF(psf), .I_CARD_PRESENT(card),
        .I_STBY_ALARMS(stby), .I_WORK_LED(work_led), .O_TX_K1(tx_k1),
        .O_TX_K2(tx_k2), .O_LOOP_WORK(lpw), .O_LOOP_PROT(lpp), .O_XOVER(xover),
        .O_WORK_BC_LED(wbc), .O_PROT_BC_LED(pbc), .O_PROT_PORT_LED(ppl),
        .O_ALARM_CODE(code), .O_STBY_STATUS(stby_st), .O_IRQ(irq));
    remote_aps_end far (.i_clk(clk), .i_rst_n(rst_n), .i_k1(rk1),
        .i_k2(rk2), .i_jitter(jit), .o_k1(k1), .o_k2(k2));

    // Ends the run with the counts and the verdict.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Lets outputs of the coming edges land before they are read.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Write with both channels offered together, then wait for the answer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        bit aw = 0, w = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready === 1'b1) awvalid <= 1'b0;
            if (!w && wready === 1'b1) wvalid <= 1'b0;
            aw = aw || awready === 1'b1;
            w = w || wready === 1'b1;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        `CHK(bresp, er)
    endtask

    // Read one word and compare data and response.
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        `CHK(rdata, ed)
        `CHK(rresp, er)
    endtask

    // Waits a bounded time for the alarm code, then compares it.
    task automatic want(input alarm_code_t e);
        for (int n = 0; n < 40 && code !== e; n++) settle(1);
        `CHK(code, e)
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // =====================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 32'h0);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_RXK, 32'h1234, RESP_SLVERR);
        wr(OFS_IRQ_ST, 32'h1, RESP_SLVERR);
        rd(OFS_IRQ_CLR, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 14; i++) begin
            rk1 <= tc[i][15:8];
            rk2 <= tc[i][7:0];
            jit <= (i == 13);
            card <= (i == 5) ? 4'hE : 4'hF;
            stby <= (i < 2) ? 12'h1 : 12'h0;
            wr(OFS_TXK, {16'h0, 8'hA5, tc[i][23:16]});
            wr(OFS_CTRL, {24'h0, tc[i][31:24]});
            want(t_exp[i]);
            `CHK(tx_k1, tc[i][23:16])
            `CHK(tx_k2, 8'hA5)
        end
        $display("test alarms done");
        jit <= 1'b0;
        rk1 <= 8'h0;
        rk2 <= 8'h4;
        wr(OFS_CTRL, 32'h1);
        want(CODE_OK);
        wr(OFS_IRQ_CLR, 32'hFF);
        wr(OFS_IRQ_EN, 32'h1);
        rk2 <= 8'h6;
        want(CODE_RSF);
        settle(2);
        `CHK(irq, 1'b1)
        // The K byte change also latches the unsteady-protocol bit.
        rd(OFS_IRQ_ST, 32'h5);
        wr(OFS_IRQ_EN, 32'h0);
        settle(2);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_EN, 32'h1);
        settle(2);
        `CHK(irq, 1'b1)
        rk2 <= 8'h4;
        want(CODE_OK);
        wr(OFS_IRQ_CLR, 32'h5);
        settle(2);
        `CHK(irq, 1'b0)
        rd(OFS_IRQ_ST, 32'h0);
        $display("test interrupt done");
        work_led <= LED_RED;
        settle(2);
        `CHK(ppl, LED_RED)
        wr(OFS_CTRL, 32'hC5);
        settle(3);
        `CHK(xover, 1'b1)
        `CHK(wbc, LED_GREEN)
        `CHK(pbc, LED_GREEN)
        wr(OFS_CTRL, 32'h85);
        settle(3);
        `CHK(wbc, LED_GREEN)
        `CHK(pbc, LED_YELLOW)
        stby <= 12'hA5A;
        settle(2);
        `CHK(stby_st, 12'hA5A)
        rd(OFS_LINE, 32'hA5A);
        $display("test leds done");
        final_report();
    end
endmodule

bind aps_alarm_monitor aps_alarm_monitor_checker u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .I_WORK_LED(I_WORK_LED), .I_STBY_ALARMS(I_STBY_ALARMS),
    .O_PROT_PORT_LED(O_PROT_PORT_LED), .O_STBY_STATUS(O_STBY_STATUS),
    .O_LOOP_WORK(O_LOOP_WORK), .O_LOOP_PROT(O_LOOP_PROT), .O_XOVER(O_XOVER),
    .O_WORK_BC_LED(O_WORK_BC_LED), .O_PROT_BC_LED(O_PROT_BC_LED),
    .O_ALARM_CODE(O_ALARM_CODE));

// ==== testbench/remote_aps_end.sv ====
// Model of the far line end that sends K bytes to the monitor.
// Assumes the bench sets the wanted request and mode bytes.
`timescale 1ns/1ps

module remote_aps_end (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Wanted bytes and an unsteady-protocol switch.
    input  wire logic [7:0] i_k1,
    input  wire logic [7:0] i_k2,
    input  wire logic       i_jitter,
    // Bytes on the line.
    output logic      [7:0] o_k1,
    output logic      [7:0] o_k2
);
    // Sends the wanted bytes, or flips them every cycle when unsteady.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_k1 <= 8'h00;
            o_k2 <= 8'h04;
        end else if (i_jitter) begin
            o_k1 <= ~o_k1;
            o_k2 <= o_k2 ^ 8'h01;
        end else begin
            o_k1 <= i_k1;
            o_k2 <= i_k2;
        end
    end
endmodule
